// >>> esfr_pkg.sv
// Constants for the extension special-function-register block
package esfr_pkg;
  localparam logic [7:0] ADDR_PAGE_HIGH_BYTE   = 8'hA1;
  localparam logic [7:0] ADDR_EXT_ADDR_CONTROL = 8'hA2;
  localparam logic [7:0] ADDR_AUX_PORT_DATA    = 8'hA6;
  localparam logic [7:0] ADDR_EXTRA_IRQ_CTRL   = 8'hC0;
  localparam logic [7:0] RST_PAGE_HIGH_BYTE    = 8'h00;
  localparam logic [7:0] RST_EXT_ADDR_CONTROL  = 8'h70;
  localparam logic [7:0] RST_AUX_PORT_DATA     = 8'hFF;
  localparam logic [7:0] RST_EXTRA_IRQ_CTRL    = 8'h00;
  localparam logic [2:0] EAC_RSVD_VALUE        = 3'h7;
  localparam int         EAC_MODE_BIT          = 7;
  localparam int         EAC_RSVD_HI           = 6;
  localparam int         EAC_RSVD_LO           = 4;
  localparam int         XIC_TRIG_A            = 0;
  localparam int         XIC_REQ_A             = 1;
  localparam int         XIC_EN_A              = 2;
  localparam int         XIC_PRI_A             = 3;
  localparam int         XIC_B_OFS             = 4;
  localparam logic [7:0] VEC_EXTRA_A           = 8'h33;
  localparam logic [7:0] VEC_EXTRA_B           = 8'h3B;
  localparam logic [2:0] POLL_EXTRA_A          = 3'h6;
  localparam logic [2:0] POLL_EXTRA_B          = 3'h7;
  localparam logic [3:0] UPPER_ZERO            = 4'h0;
  typedef enum logic [1:0] {
    ESFR_RUN   = 2'b00,
    ESFR_IDLE  = 2'b01,
    ESFR_PDOWN = 2'b10
  } esfr_pwr_t;
endpackage : esfr_pkg

// >>> esfr_irq_chan.sv
// One extra external interrupt channel: trigger detect and request flag
`timescale 1ns/10ps
module esfr_irq_chan
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic pin_n,
  input  wire logic trig_edge,
  input  wire logic serviced,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  output logic      flag_r,
  output logic      request
);
  logic pin_d_r;
  logic fall;
  logic flag_nxt;

  assign fall = pin_d_r & ~pin_n;
  // set on edge, clear on service; set wins
  assign flag_nxt = (trig_edge & fall) ? 1'b1 :
                    (serviced & trig_edge) ? 1'b0 :
                    sw_wr ? sw_val : flag_r;
  assign request = trig_edge ? flag_r : ~pin_n;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_d_r <= 1'b1;
      flag_r  <= 1'b0;
    end
    else
    begin
      pin_d_r <= pin_n;
      flag_r  <= flag_nxt;
    end
  end

  property p_edge_sets;
    @(posedge clk_sys) disable iff (sys_rst)
      (trig_edge && pin_d_r && !pin_n) |=> flag_r;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag");

  property p_level_req;
    @(posedge clk_sys) disable iff (sys_rst)
      !trig_edge |-> (request == !pin_n);
  endproperty
  a_level_req: assert property (p_level_req) else $error("level request wrong");
endmodule : esfr_irq_chan

// >>> esfr_top.sv
// Extension SFRs: upper address/chip select, aux port, extra interrupts, page byte
`timescale 1ns/10ps
module esfr_top
  import esfr_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic [7:0]       sfr_wdata,
  input  wire logic             sfr_rd,
  output logic      [7:0]       sfr_rdata,
  input  wire logic             bit_wr,
  input  wire logic [7:0]       bit_addr,
  input  wire logic             bit_val,
  output logic                  bit_rdata,
  input  wire logic [15:0]      core_addr,
  input  wire logic             core_ale,
  input  wire logic             core_program_store_en_n_n,
  input  wire logic             code_space_read,
  input  wire logic             ext_data_move,
  input  wire logic             paged_external_move,
  input  wire esfr_pkg::esfr_pwr_t pwr_mode,
  output logic      [7:0]       low_addr_port,
  output logic      [7:0]       high_addr_port,
  output logic      [3:0]       upper_addr_select_pins,
  output logic                  ale,
  output logic                  program_store_en_n,
  input  wire logic [7:0]       aux_port_in,
  output logic      [7:0]       aux_port_out,
  input  wire logic             extra_irq_a_n,
  input  wire logic             extra_irq_b_n,
  input  wire logic             service_a,
  input  wire logic             service_b,
  output logic                  irq_req_a,
  output logic                  irq_req_b,
  output logic                  irq_hi_a,
  output logic                  irq_hi_b,
  output logic      [7:0]       irq_vector,
  output logic      [2:0]       irq_poll_rank,
  output logic                  irq_vector_valid
);
  import esfr_pkg::*;

  logic [7:0] page_high_byte_r;
  logic [7:0] ext_addr_control_r;
  logic [7:0] aux_port_data_r;
  logic [7:0] extra_irq_control_r;
  logic [7:0] xic_nxt;
  logic [7:0] eac_nxt;
  logic [7:0] eac_view;
  logic [7:0] high_addr_nxt;
  logic [3:0] upper_nxt;
  logic [3:0] cs_decode_n;
  logic       hit_phb;
  logic       hit_eac;
  logic       hit_aux;
  logic       hit_xic;
  logic       bit_hit;
  logic [2:0] bit_idx;
  logic       chip_sel_mode;
  logic       data_access;
  logic [1:0] flag_r;
  logic [7:0] xic_view;
  logic [1:0] raw_req;
  logic [1:0] trig;
  logic [1:0] service;
  logic [1:0] pin_n;
  logic [1:0] sw_flag_wr;
  logic [1:0] sw_flag_val;
  logic [3:0] cs_hold_n;

  assign hit_phb = (sfr_addr == ADDR_PAGE_HIGH_BYTE);
  assign hit_eac = (sfr_addr == ADDR_EXT_ADDR_CONTROL);
  assign hit_aux = (sfr_addr == ADDR_AUX_PORT_DATA);
  assign hit_xic = (sfr_addr == ADDR_EXTRA_IRQ_CTRL);
  // only the irq control answers bit addresses
  assign bit_hit = (bit_addr[7:3] == ADDR_EXTRA_IRQ_CTRL[7:3]);
  assign bit_idx = bit_addr[2:0];

  // reserved bits always read as ones
  assign eac_view = {ext_addr_control_r[EAC_MODE_BIT], EAC_RSVD_VALUE,
                     ext_addr_control_r[3:0]};
  assign eac_nxt = (sfr_wr && hit_eac) ?
                   {sfr_wdata[EAC_MODE_BIT], EAC_RSVD_VALUE, sfr_wdata[3:0]} :
                   ext_addr_control_r;

  // reads of aux port return pin levels
  assign sfr_rdata = hit_phb ? page_high_byte_r :
                     hit_eac ? eac_view :
                     hit_aux ? aux_port_in :
                     hit_xic ? xic_view : 8'h00;
  assign bit_rdata = bit_hit ? xic_view[bit_idx] : 1'b0;

  // Request flags read live from the channels, not a cycle late
  assign xic_view = {extra_irq_control_r[7:6], flag_r[1], extra_irq_control_r[4:2],
                     flag_r[0], extra_irq_control_r[0]};
  assign trig    = {extra_irq_control_r[XIC_TRIG_A + XIC_B_OFS],
                    extra_irq_control_r[XIC_TRIG_A]};
  assign service = {service_b, service_a};
  assign pin_n   = {extra_irq_b_n, extra_irq_a_n};

  // Per-channel detector, software writes to the flag bit pass through it
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_chan
      localparam int FB = XIC_REQ_A + g * XIC_B_OFS;
      assign sw_flag_wr[g]  = (sfr_wr && hit_xic) ||
                              (bit_wr && bit_hit && (bit_idx == FB[2:0]));
      assign sw_flag_val[g] = (sfr_wr && hit_xic) ? sfr_wdata[FB] : bit_val;
      esfr_irq_chan u_chan
      (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .pin_n     (pin_n[g]),
        .trig_edge (trig[g]),
        .serviced  (service[g]),
        .sw_wr     (sw_flag_wr[g]),
        .sw_val    (sw_flag_val[g]),
        .flag_r    (flag_r[g]),
        .request   (raw_req[g])
      );
    end
  endgenerate

  // Byte and bit writes to the irq control; flags owned by channels
  always_comb
  begin
    xic_nxt = extra_irq_control_r;
    if (sfr_wr && hit_xic)
      xic_nxt = sfr_wdata;
    else if (bit_wr && bit_hit)
      xic_nxt[bit_idx] = bit_val;
    xic_nxt[XIC_REQ_A]             = flag_r[0];
    xic_nxt[XIC_REQ_A + XIC_B_OFS] = flag_r[1];
  end

  assign irq_req_a = raw_req[0] & extra_irq_control_r[XIC_EN_A];
  assign irq_req_b = raw_req[1] & extra_irq_control_r[XIC_EN_A + XIC_B_OFS];
  assign irq_hi_a  = extra_irq_control_r[XIC_PRI_A];
  assign irq_hi_b  = extra_irq_control_r[XIC_PRI_A + XIC_B_OFS];
  assign irq_vector_valid = irq_req_a | irq_req_b;
  assign irq_vector = (irq_req_a && (irq_hi_a || !irq_hi_b || !irq_req_b)) ?
                      VEC_EXTRA_A : (irq_req_b ? VEC_EXTRA_B : 8'h00);
  // within a level A is polled before B
  assign irq_poll_rank = (irq_vector == VEC_EXTRA_A) ? POLL_EXTRA_A :
                         (irq_req_b ? POLL_EXTRA_B : 3'h0);

  assign chip_sel_mode = ext_addr_control_r[EAC_MODE_BIT];
  // page byte on high port during paged moves
  assign high_addr_nxt = paged_external_move ? page_high_byte_r : core_addr[15:8];
  // select k covers 16K window k
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_cs
      localparam logic [1:0] IDX = 2'(g);
      assign cs_decode_n[g] = ~(high_addr_nxt[7:6] == IDX);
      assign cs_hold_n[g]   = ~(high_addr_port[7:6] == IDX);
    end
  endgenerate
  // nibble only during code-space reads or external data moves
  assign data_access = code_space_read | ext_data_move;
  // nibble or zero, or decode; low-power modes give the held decode or zero
  assign upper_nxt = chip_sel_mode ? cs_decode_n :
                     (data_access ? ext_addr_control_r[3:0] : UPPER_ZERO);

  // strobes forced in idle and power-down
  assign ale = (pwr_mode == ESFR_IDLE) ? 1'b1 :
               (pwr_mode == ESFR_PDOWN) ? 1'b0 : core_ale;
  assign program_store_en_n = (pwr_mode == ESFR_IDLE) ? 1'b1 :
                              (pwr_mode == ESFR_PDOWN) ? 1'b0 : core_program_store_en_n_n;
  assign aux_port_out = aux_port_data_r;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      page_high_byte_r       <= RST_PAGE_HIGH_BYTE;
      ext_addr_control_r     <= RST_EXT_ADDR_CONTROL;
      aux_port_data_r        <= RST_AUX_PORT_DATA;
      extra_irq_control_r    <= RST_EXTRA_IRQ_CTRL;
      low_addr_port          <= 8'h00;
      high_addr_port         <= 8'h00;
      upper_addr_select_pins <= UPPER_ZERO;
    end
    else
    begin
      if (sfr_wr && hit_phb)
        page_high_byte_r <= sfr_wdata;
      if (sfr_wr && hit_aux)
        aux_port_data_r <= sfr_wdata;
      ext_addr_control_r  <= eac_nxt;
      extra_irq_control_r <= xic_nxt;
      // Address ports hold their value in low-power modes
      if (pwr_mode == ESFR_IDLE || pwr_mode == ESFR_PDOWN)
      begin
        low_addr_port  <= low_addr_port;
        high_addr_port <= high_addr_port;
      end
      else
      begin
        low_addr_port  <= core_addr[7:0];
        high_addr_port <= high_addr_nxt;
      end
      upper_addr_select_pins <= (pwr_mode == ESFR_RUN) ? upper_nxt :
        (chip_sel_mode ? cs_hold_n : UPPER_ZERO);
    end
  end

  property p_rsvd_read;
    @(posedge clk_sys) disable iff (sys_rst)
      hit_eac |-> (sfr_rdata[EAC_RSVD_HI:EAC_RSVD_LO] == 3'h7);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits not 111");

  // exactly one select low in chip-select mode
  property p_one_cs;
    @(posedge clk_sys) disable iff (sys_rst)
      $past(chip_sel_mode) && $past(pwr_mode == ESFR_RUN) |->
        $countones(~upper_addr_select_pins) == 1;
  endproperty
  a_one_cs: assert property (p_one_cs) else $error("not exactly one select");

  // select zero low for window 0000H-3FFFH
  property p_cs_window;
    @(posedge clk_sys) disable iff (sys_rst)
      chip_sel_mode && !paged_external_move && core_addr[15:14] == 2'b00
        && pwr_mode == ESFR_RUN |=> !upper_addr_select_pins[0];
  endproperty
  a_cs_window: assert property (p_cs_window) else $error("select zero wrong");

  // zero on fetch in address mode
  property p_fetch_zero;
    @(posedge clk_sys) disable iff (sys_rst)
      !chip_sel_mode && !data_access |=> upper_addr_select_pins == 4'h0;
  endproperty
  a_fetch_zero: assert property (p_fetch_zero) else $error("upper pins not zero");

  property p_nibble;
    @(posedge clk_sys) disable iff (sys_rst)
      !chip_sel_mode && data_access && pwr_mode == ESFR_RUN |=>
        upper_addr_select_pins == $past(ext_addr_control_r[3:0]);
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble not driven");

  property p_page;
    @(posedge clk_sys) disable iff (sys_rst)
      paged_external_move && pwr_mode == ESFR_RUN |=>
        high_addr_port == $past(page_high_byte_r);
  endproperty
  a_page: assert property (p_page) else $error("page byte not on port");

  property p_pdown;
    @(posedge clk_sys) disable iff (sys_rst)
      pwr_mode == ESFR_PDOWN |-> !ale && !program_store_en_n;
  endproperty
  a_pdown: assert property (p_pdown) else $error("strobes not low");

  property p_enable;
    @(posedge clk_sys) disable iff (sys_rst)
      !extra_irq_control_r[XIC_EN_A] |-> !irq_req_a;
  endproperty
  a_enable: assert property (p_enable) else $error("disabled irq requested");

  property p_eac_write;
    @(posedge clk_sys) disable iff (sys_rst)
      sfr_wr && hit_eac |=>
        eac_view == {$past(sfr_wdata[EAC_MODE_BIT]), EAC_RSVD_VALUE, $past(sfr_wdata[3:0])};
  endproperty
  a_eac_write: assert property (p_eac_write) else $error("reserved bits written");

  // written byte appears on the pins
  property p_aux_write;
    @(posedge clk_sys) disable iff (sys_rst)
      sfr_wr && hit_aux |=> aux_port_out == $past(sfr_wdata);
  endproperty
  a_aux_write: assert property (p_aux_write) else $error("aux pins not written");

  property p_aux_read;
    @(posedge clk_sys) disable iff (sys_rst)
      hit_aux |-> sfr_rdata == aux_port_in;
  endproperty
  a_aux_read: assert property (p_aux_read) else $error("aux read not pins");

  property p_poll_order;
    @(posedge clk_sys) disable iff (sys_rst)
      irq_req_a && irq_req_b && (irq_hi_a == irq_hi_b) |->
        irq_vector == VEC_EXTRA_A && irq_poll_rank == POLL_EXTRA_A;
  endproperty
  a_poll_order: assert property (p_poll_order) else $error("poll order wrong");

  property p_idle;
    @(posedge clk_sys) disable iff (sys_rst)
      pwr_mode == ESFR_IDLE |-> ale && program_store_en_n;
  endproperty
  a_idle: assert property (p_idle) else $error("strobes not high");

  // Idle or power-down in force at this edge
  sequence s_low_power;
    pwr_mode != ESFR_RUN;
  endsequence

  // address ports hold in low power
  property p_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      s_low_power |=> $stable(high_addr_port) && $stable(low_addr_port);
  endproperty
  a_hold: assert property (p_hold) else $error("address ports moved");

  property p_lp_sel;
    @(posedge clk_sys) disable iff (sys_rst)
      s_low_power |=> upper_addr_select_pins ==
        ($past(chip_sel_mode) ? $past(cs_hold_n) : UPPER_ZERO);
  endproperty
  a_lp_sel: assert property (p_lp_sel) else $error("low-power upper pins wrong");
endmodule : esfr_top

// >>> esfr_mem_model.sv
// Memory-mapped peripheral bank that sits on the select pins
`timescale 1ns/10ps
module esfr_mem_model
(
  input  wire logic [3:0] sel_n,
  output logic      [2:0] n_sel
);
  // More than one bank selected would clash on the shared data bus
  always_comb
  begin
    n_sel = 3'(!sel_n[0]) + 3'(!sel_n[1]) + 3'(!sel_n[2]) + 3'(!sel_n[3]);
  end
endmodule : esfr_mem_model

// >>> esfr_tb_top.sv
// Self-checking bench for the extension register block
`timescale 1ns/10ps
module esfr_tb_top;
  import esfr_pkg::*;
  typedef struct {int id; logic [7:0] exp;} esfr_note_t;
  logic        clk_sys = 1'b0, sys_rst = 1'b1;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, aux_port_in = 8'h00;
  logic        sfr_wr = 1'b0, sfr_rd = 1'b0, bit_wr = 1'b0, bit_val = 1'b0;
  logic [15:0] core_addr = 16'h0000;
  logic        core_ale = 1'b0, core_program_store_en_n_n = 1'b1, code_space_read = 1'b0;
  logic        ext_data_move = 1'b0, paged_external_move = 1'b0;
  logic        extra_irq_a_n = 1'b1, extra_irq_b_n = 1'b1, service_a = 1'b0, service_b = 1'b0;
  esfr_pwr_t   pwr_mode = ESFR_RUN;
  logic [7:0]  sfr_rdata, low_addr_port, high_addr_port, aux_port_out, irq_vector, v, pg;
  logic [3:0]  upper_addr_select_pins;
  logic [2:0]  irq_poll_rank, n_sel;
  logic        bit_rdata, ale, program_store_en_n, irq_req_a, irq_req_b;
  logic        irq_hi_a, irq_hi_b, irq_vector_valid;
  logic [15:0] bnd [8] = '{16'h0000, 16'h3FFF, 16'h4000, 16'h7FFF,
                           16'h8000, 16'hBFFF, 16'hC000, 16'hFFFF};
  int          seed, n_mismatch = 0, comparisons = 0;
  esfr_note_t  notes [$];
  esfr_note_t  cur;
  logic [7:0]  got;
  event        ev_res;
  string       nm [16] = '{"rdata", "bit", "upper", "high", "aux", "req_a", "req_b",
                           "vector", "ale", "store_en", "rank", "hi_a", "n_sel", "low",
                           "hi_b", "valid"};

  esfr_top u_esfr_top (.clk_sys, .sys_rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
    .sfr_rdata, .bit_wr, .bit_addr, .bit_val, .bit_rdata, .core_addr, .core_ale,
    .core_program_store_en_n_n, .code_space_read, .ext_data_move, .paged_external_move, .pwr_mode,
    .low_addr_port, .high_addr_port, .upper_addr_select_pins, .ale, .program_store_en_n,
    .aux_port_in, .aux_port_out, .extra_irq_a_n, .extra_irq_b_n, .service_a, .service_b,
    .irq_req_a, .irq_req_b, .irq_hi_a, .irq_hi_b, .irq_vector, .irq_poll_rank,
    .irq_vector_valid);
  esfr_mem_model u_esfr_mem_model (.sel_n(upper_addr_select_pins), .n_sel(n_sel));

  always #50 clk_sys = ~clk_sys;

  function automatic logic [7:0] obs(input int id);
    case (id)
      0: return sfr_rdata;
      1: return {7'h00, bit_rdata};
      2: return {4'h0, upper_addr_select_pins};
      3: return high_addr_port;
      4: return aux_port_out;
      5: return {7'h00, irq_req_a};
      6: return {7'h00, irq_req_b};
      7: return irq_vector;
      8: return {7'h00, ale};
      9: return {7'h00, program_store_en_n};
      10: return {5'h00, irq_poll_rank};
      11: return {7'h00, irq_hi_a};
      12: return {5'h00, n_sel};
      13: return low_addr_port;
      14: return {7'h00, irq_hi_b};
      default: return {7'h00, irq_vector_valid};
    endcase
  endfunction : obs

  // Watcher drains all pending notes, oldest first, whenever a result is flagged
  initial forever
  begin
    @(ev_res);
    while (notes.size() > 0)
    begin
      cur = notes.pop_front();
      got = obs(cur.id);
      comparisons++;
      if (got !== cur.exp)
      begin
        n_mismatch++;
        $display("[ERR] %s expected %h seen %h", nm[cur.id], cur.exp, got);
      end
    end
  end

  task automatic chk(input int id, input logic [7:0] e);
    #1;
    notes.push_back('{id, e});
    -> ev_res;
    #1;
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    chk(0, e);
    sfr_rd = 1'b0;
  endtask : rd

  task automatic bw(input logic [7:0] a, input logic b);
    cyc(1);
    bit_addr = a;
    bit_val = b;
    bit_wr = 1'b1;
    cyc(1);
    bit_wr = 1'b0;
  endtask : bw

  task automatic bchk(input logic [7:0] a, input logic e);
    bit_addr = a;
    chk(1, {7'h00, e});
  endtask : bchk

  task automatic final_report;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  initial
  begin
    seed = 32'h9B1717F3;
    aux_port_in = 8'($random(seed));
    repeat (20) @(posedge clk_sys);
    cyc(1);
    sys_rst = 1'b0;
    rd(ADDR_PAGE_HIGH_BYTE, 8'h00);
    rd(ADDR_EXT_ADDR_CONTROL, 8'h70);
    rd(ADDR_AUX_PORT_DATA, aux_port_in);
    rd(ADDR_EXTRA_IRQ_CTRL, 8'h00);
    rd(8'hA3, 8'h00);
    chk(4, 8'hFF);
    wr(ADDR_EXT_ADDR_CONTROL, 8'h8A);
    rd(ADDR_EXT_ADDR_CONTROL, 8'hFA);
    v = 8'($random(seed)) & 8'h0F;
    wr(ADDR_EXT_ADDR_CONTROL, v);
    rd(ADDR_EXT_ADDR_CONTROL, v | 8'h70);
    core_addr = 16'($random(seed));
    code_space_read = 1'b1;
    cyc(1);
    chk(2, v);
    chk(3, core_addr[15:8]);
    code_space_read = 1'b0;
    cyc(1);
    chk(2, 8'h00);
    ext_data_move = 1'b1;
    cyc(1);
    chk(2, v);
    ext_data_move = 1'b0;
    wr(ADDR_EXT_ADDR_CONTROL, 8'h80);
    for (int i = 0; i < 8; i++)
    begin
      core_addr = bnd[i];
      cyc(1);
      chk(2, {4'h0, ~(4'h1 << i[2:1])});
      chk(12, 8'h01);
    end
    pg = 8'($random(seed));
    wr(ADDR_PAGE_HIGH_BYTE, pg);
    rd(ADDR_PAGE_HIGH_BYTE, pg);
    paged_external_move = 1'b1;
    cyc(1);
    chk(3, pg);
    chk(2, {4'h0, ~(4'h1 << pg[7:6])});
    paged_external_move = 1'b0;
    v = 8'($random(seed));
    wr(ADDR_AUX_PORT_DATA, v);
    chk(4, v);
    aux_port_in = 8'($random(seed));
    rd(ADDR_AUX_PORT_DATA, aux_port_in);
    bw(8'hC0, 1'b1);
    bw(8'hC2, 1'b1);
    rd(ADDR_EXTRA_IRQ_CTRL, 8'h05);
    extra_irq_a_n = 1'b0;
    cyc(2);
    bchk(8'hC1, 1'b1);
    chk(5, 8'h01);
    chk(7, VEC_EXTRA_A);
    chk(10, 8'h06);
    chk(15, 8'h01);
    extra_irq_a_n = 1'b1;
    service_a = 1'b1;
    cyc(1);
    service_a = 1'b0;
    bchk(8'hC1, 1'b0);
    chk(5, 8'h00);
    chk(15, 8'h00);
    bw(8'hC6, 1'b1);
    extra_irq_b_n = 1'b0;
    chk(6, 8'h01);
    chk(7, VEC_EXTRA_B);
    chk(10, 8'h07);
    bw(8'hC0, 1'b0);
    extra_irq_a_n = 1'b0;
    chk(7, VEC_EXTRA_A);
    bw(8'hC7, 1'b1);
    chk(14, 8'h01);
    chk(7, VEC_EXTRA_B);
    bw(8'hC3, 1'b1);
    chk(11, 8'h01);
    chk(7, VEC_EXTRA_A);
    bw(8'hC2, 1'b0);
    chk(5, 8'h00);
    extra_irq_a_n = 1'b1;
    extra_irq_b_n = 1'b1;
    chk(15, 8'h00);
    core_addr = 16'h8123;
    cyc(1);
    core_addr = 16'h0000;
    core_program_store_en_n_n = 1'b0;
    pwr_mode = ESFR_IDLE;
    cyc(1);
    chk(8, 8'h01);
    chk(9, 8'h01);
    chk(2, 8'h0B);
    chk(3, 8'h81);
    chk(13, 8'h23);
    core_ale = 1'b1;
    core_program_store_en_n_n = 1'b1;
    pwr_mode = ESFR_PDOWN;
    cyc(1);
    chk(8, 8'h00);
    chk(9, 8'h00);
    chk(3, 8'h81);
    chk(2, 8'h0B);
    final_report();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    final_report();
  end
endmodule : esfr_tb_top
